//--- verilog/frsl_limiter.sv
`timescale 1ns/1ps
module frsl_limiter #(
  parameter int unsigned PROG_CLKS = frsl_pkg::PROG_CYCLE_CLKS
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire frsl_pkg::frsl_mode_t mode_i,
  input  wire logic                block_i,
  input  wire logic                start_i,
  input  wire logic                hot_cold_en_i,
  input  wire logic [9:0]          theta_used_i,
  input  wire logic [63:0]         timestamp_i,
  input  wire logic [5:0]          ev_store_sel_i,
  input  wire logic                set_we_i,
  input  wire logic [2:0]          set_sel_i,
  input  wire logic [12:0]         set_val_i,
  input  wire logic [3:0]          hist_idx_i,
  output logic                     alarm_o,
  output logic                     lockout_o,
  output logic                     blocked_o,
  output logic                     hot_o,
  output logic [6:0]               used_starts_o,
  output logic [23:0]              lock_time_o,
  output logic [23:0]              since_start_o,
  output logic                     ev_valid_o,
  output logic [2:0]               ev_code_o,
  output logic                     ev_store_o,
  output logic [63:0]              ev_time_o,
  output logic                     hist_valid_o,
  output logic [63:0]              hist_time_o,
  output logic [2:0]               hist_code_o,
  output logic [23:0]              hist_lock_time_o,
  output logic [23:0]              hist_since_o,
  output logic [6:0]               hist_used_o,
  output logic [9:0]               shr_hot_lim_o,
  output logic [12:0]              shr_stall_cold_o,
  output logic [12:0]              shr_stall_hot_o,
  output logic [6:0]               shr_starts_cold_o,
  output logic [6:0]               shr_starts_hot_o,
  output logic [6:0]               shr_hours_o,
  output logic [12:0]              shr_min_gap_o
);

  localparam int unsigned REC_W = 64 + 3 + 24 + 24 + 7 + 1;

  logic                 tick_q;
  logic [19:0]          prog_cnt_q;
  logic                 deci_q;
  logic [3:0]           deci_cnt_q;
  logic                 hot;
  logic [12:0]          stall_cold_eff;
  logic [12:0]          stall;
  logic [6:0]           n_allow;
  logic [25:0]          win;
  logic [38:0]          unit;
  logic [19:0]          dec;
  logic                 enabled;
  logic                 run;
  logic                 start_ok;
  frsl_pkg::frsl_cnt_t  stress_q;
  frsl_pkg::frsl_cnt_t  stress_d;
  frsl_pkg::frsl_cnt_t  sum;
  frsl_pkg::frsl_cnt_t  upper;
  frsl_pkg::frsl_cnt_t  lower;
  logic [6:0]           used_q;
  logic                 gap_lock_q;
  logic                 alarm_d;
  logic                 lock_d;
  logic                 blk_d;
  logic [2:0]           cur;
  logic [2:0]           prev;
  logic [5:0]           edges;
  logic [5:0]           pend_q;
  logic [5:0]           grant;
  logic [2:0]           grant_idx;
  logic [REC_W-1:0]     hist_mem [frsl_pkg::HIST_DEPTH];
  logic [3:0]           wr_ptr_q;
  logic [4:0]           rd_sum;
  logic [3:0]           rd_ptr;

  // Program cycle tick; the counter clears only through reset or wrap.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_cnt_q <= 20'h00000;
      tick_q     <= 1'b0;
    end else if (prog_cnt_q == 20'(PROG_CLKS - 1)) begin
      prog_cnt_q <= 20'h00000;
      tick_q     <= 1'b1;
    end else begin
      prog_cnt_q <= prog_cnt_q + 20'h00001;
      tick_q     <= 1'b0;
    end
  end

  // Tenth of a second pulse for the time counters.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      deci_cnt_q <= 4'h0;
      deci_q     <= 1'b0;
    end else begin
      deci_q <= 1'b0;
      if (tick_q) begin
        if (deci_cnt_q == 4'(frsl_pkg::DECI_TICKS - 1)) begin
          deci_cnt_q <= 4'h0;
          deci_q     <= 1'b1;
        end else begin
          deci_cnt_q <= deci_cnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shr_hot_lim_o     <= frsl_pkg::HOT_LIM_DEF;
      shr_stall_cold_o  <= frsl_pkg::STALL_COLD_DEF;
      shr_stall_hot_o   <= frsl_pkg::STALL_HOT_DEF;
      shr_starts_cold_o <= frsl_pkg::STARTS_COLD_DEF;
      shr_starts_hot_o  <= frsl_pkg::STARTS_HOT_DEF;
      shr_hours_o       <= frsl_pkg::HOURS_DEF;
      shr_min_gap_o     <= frsl_pkg::MIN_GAP_DEF;
    end else if (set_we_i) begin
      unique case (set_sel_i)
        frsl_pkg::SEL_HOT_LIM:     shr_hot_lim_o     <= set_val_i[9:0];
        frsl_pkg::SEL_STALL_COLD:  shr_stall_cold_o  <= set_val_i;
        frsl_pkg::SEL_STALL_HOT:   shr_stall_hot_o   <= set_val_i;
        frsl_pkg::SEL_STARTS_COLD: shr_starts_cold_o <= set_val_i[6:0];
        frsl_pkg::SEL_STARTS_HOT:  shr_starts_hot_o  <= set_val_i[6:0];
        frsl_pkg::SEL_HOURS:       shr_hours_o       <= set_val_i[6:0];
        frsl_pkg::SEL_MIN_GAP:     shr_min_gap_o     <= set_val_i;
        default: ;
      endcase
    end
  end

  assign hot = hot_cold_en_i && (theta_used_i > shr_hot_lim_o);
  assign stall_cold_eff = (shr_stall_cold_o == 13'h0000) ?
                          shr_stall_hot_o : shr_stall_cold_o;
  assign stall = hot ? shr_stall_hot_o : stall_cold_eff;
  assign n_allow = hot ? shr_starts_hot_o : shr_starts_cold_o;
  assign win = 26'(shr_hours_o * frsl_pkg::TICKS_PER_HOUR);
  assign unit = 39'(stall) * 39'(win);
  assign dec = 20'(stall) * 20'(n_allow);

  assign enabled = (mode_i != frsl_pkg::MODE_OFF);
  assign run = ((mode_i == frsl_pkg::MODE_ON) ||
                (mode_i == frsl_pkg::MODE_TEST)) && !block_i;
  assign start_ok = start_i && run;

  always_comb begin
    sum = stress_q + (start_ok ? frsl_pkg::frsl_cnt_t'(unit) : '0);
    stress_d = sum;
    if (tick_q) begin
      stress_d = (sum > frsl_pkg::frsl_cnt_t'(dec)) ?
                 sum - frsl_pkg::frsl_cnt_t'(dec) : '0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stress_q <= '0;
    end else if (!enabled) begin
      stress_q <= '0;
    end else begin
      stress_q <= stress_d;
    end
  end

  // Used starts are tracked by one step per clock instead of a divider;
  // the stress moves by at most one unit per start, so it keeps up.
  assign upper = frsl_pkg::frsl_cnt_t'(used_q) *
                 frsl_pkg::frsl_cnt_t'(unit);
  assign lower = (used_q == 7'h00) ? '0 :
                 frsl_pkg::frsl_cnt_t'(used_q - 7'h01) *
                 frsl_pkg::frsl_cnt_t'(unit);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      used_q <= 7'h00;
    end else if (stress_q > upper && used_q != 7'h7f) begin
      used_q <= used_q + 7'h01;
    end else if (used_q != 7'h00 && stress_q <= lower) begin
      used_q <= used_q - 7'h01;
    end
  end

  // Time since the last start, saturating.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_start_o <= 24'hffffff;
    end else if (start_ok) begin
      since_start_o <= 24'h000000;
    end else if (deci_q && since_start_o != 24'hffffff) begin
      since_start_o <= since_start_o + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_lock_q <= 1'b0;
    end else if (!enabled) begin
      gap_lock_q <= 1'b0;
    end else if (start_ok &&
                 since_start_o < 24'(shr_min_gap_o)) begin
      gap_lock_q <= 1'b1;
    end else if (since_start_o >= 24'(shr_min_gap_o)) begin
      gap_lock_q <= 1'b0;
    end
  end

  assign alarm_d = run && (used_q + 7'h01 == n_allow);
  assign lock_d = run && ((used_q >= n_allow) || gap_lock_q);
  assign blk_d = (mode_i == frsl_pkg::MODE_BLOCKED) ||
                 (mode_i == frsl_pkg::MODE_TEST_BLK) ||
                 (enabled && block_i);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_o       <= 1'b0;
      lockout_o     <= 1'b0;
      blocked_o     <= 1'b0;
      hot_o         <= 1'b0;
      used_starts_o <= 7'h00;
    end else begin
      alarm_o       <= alarm_d;
      lockout_o     <= lock_d;
      blocked_o     <= blk_d;
      hot_o         <= hot;
      used_starts_o <= used_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_time_o <= 24'h000000;
    end else if (lock_d && !lockout_o) begin
      lock_time_o <= 24'h000000;
    end else if (lockout_o && deci_q && lock_time_o != 24'hffffff) begin
      lock_time_o <= lock_time_o + 24'h000001;
    end
  end

  assign cur  = {blk_d, lock_d, alarm_d};
  assign prev = {blocked_o, lockout_o, alarm_o};

  for (genvar g = 0; g < frsl_pkg::EV_SRCS; g++) begin : g_edge
    assign edges[2*g]     = cur[g] && !prev[g];
    assign edges[2*g + 1] = !cur[g] && prev[g];
  end

  // Only one event leaves per clock, so edges wait here; a new edge in
  // the cycle its bit is granted stays pending.
  assign grant = pend_q & (~pend_q + 6'h01);

  always_comb begin
    grant_idx = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (grant[i]) begin
        grant_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 6'h00;
    end else begin
      pend_q <= (pend_q & ~grant) | edges;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_valid_o <= 1'b0;
      ev_code_o  <= 3'h0;
      ev_store_o <= 1'b0;
      ev_time_o  <= 64'h0000000000000000;
    end else begin
      ev_valid_o <= |pend_q;
      ev_code_o  <= grant_idx;
      ev_store_o <= |(grant & ev_store_sel_i);
      ev_time_o  <= timestamp_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= 4'h0;
      for (int i = 0; i < frsl_pkg::HIST_DEPTH; i++) begin
        hist_mem[i] <= '0;
      end
    end else if (|pend_q) begin
      hist_mem[wr_ptr_q] <= {1'b1, timestamp_i, grant_idx, lock_time_o,
                             since_start_o, used_q};
      wr_ptr_q <= (wr_ptr_q == 4'(frsl_pkg::HIST_DEPTH - 1)) ?
                  4'h0 : wr_ptr_q + 4'h1;
    end
  end

  // Index zero reads the newest record.
  assign rd_sum = 5'(wr_ptr_q) + 5'(frsl_pkg::HIST_DEPTH - 1) -
                  5'(hist_idx_i);
  assign rd_ptr = (rd_sum >= 5'(frsl_pkg::HIST_DEPTH)) ?
                  4'(rd_sum - 5'(frsl_pkg::HIST_DEPTH)) : rd_sum[3:0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_valid_o     <= 1'b0;
      hist_time_o      <= 64'h0000000000000000;
      hist_code_o      <= 3'h0;
      hist_lock_time_o <= 24'h000000;
      hist_since_o     <= 24'h000000;
      hist_used_o      <= 7'h00;
    end else if (hist_idx_i < 4'(frsl_pkg::HIST_DEPTH)) begin
      {hist_valid_o, hist_time_o, hist_code_o, hist_lock_time_o,
       hist_since_o, hist_used_o} <= hist_mem[rd_ptr];
    end else begin
      hist_valid_o     <= 1'b0;
      hist_time_o      <= 64'h0000000000000000;
      hist_code_o      <= 3'h0;
      hist_lock_time_o <= 24'h000000;
      hist_since_o     <= 24'h000000;
      hist_used_o      <= 7'h00;
    end
  end

endmodule

//--- verilog/frsl_pkg.sv
package frsl_pkg;

  // Clock and program cycle timing.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned PROG_CYCLE_MS   = 10;
  localparam int unsigned PROG_CYCLE_CLKS =
    PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DECI_MS         = 100;
  localparam int unsigned DECI_TICKS      = DECI_MS / PROG_CYCLE_MS;
  localparam int unsigned HOUR_MS         = 3600000;
  localparam int unsigned TICKS_PER_HOUR  = HOUR_MS / PROG_CYCLE_MS;

  // Widths of settings and counters.
  localparam int unsigned PCT_W   = 10;
  localparam int unsigned TIME_W  = 13;
  localparam int unsigned CNT_W   = 7;
  localparam int unsigned HOUR_W  = 7;
  localparam int unsigned WIN_W   = 26;
  localparam int unsigned UNIT_W  = 39;
  localparam int unsigned DEC_W   = 20;
  localparam int unsigned SINCE_W = 24;
  localparam int unsigned TS_W    = 64;
  localparam int unsigned EV_W    = 3;
  localparam int unsigned PTR_W   = 4;
  localparam int unsigned HIST_DEPTH = 12;

  typedef logic [47:0] frsl_cnt_t;

  // Motor data defaults; hot limit in 0.1 %, times in 0.1 s steps, starts and hours as plain counts.
  localparam logic [PCT_W-1:0]  HOT_LIM_DEF    = 10'h2bc;
  localparam logic [TIME_W-1:0] STALL_COLD_DEF = 13'h00c8;
  localparam logic [TIME_W-1:0] STALL_HOT_DEF  = 13'h0096;
  localparam logic [CNT_W-1:0]  STARTS_COLD_DEF = 7'h03;
  localparam logic [CNT_W-1:0]  STARTS_HOT_DEF  = 7'h02;
  localparam logic [HOUR_W-1:0] HOURS_DEF      = 7'h01;
  localparam logic [TIME_W-1:0] MIN_GAP_DEF    = 13'h00c8;

  // Shared setting write selectors.
  localparam logic [2:0] SEL_HOT_LIM     = 3'h0;
  localparam logic [2:0] SEL_STALL_COLD  = 3'h1;
  localparam logic [2:0] SEL_STALL_HOT   = 3'h2;
  localparam logic [2:0] SEL_STARTS_COLD = 3'h3;
  localparam logic [2:0] SEL_STARTS_HOT  = 3'h4;
  localparam logic [2:0] SEL_HOURS       = 3'h5;
  localparam logic [2:0] SEL_MIN_GAP     = 3'h6;

  // Event sources; event code is source * 2 plus one for OFF.
  localparam int unsigned EV_ALARM = 0;
  localparam int unsigned EV_LOCK  = 1;
  localparam int unsigned EV_BLK   = 2;
  localparam int unsigned EV_SRCS  = 3;

  typedef enum logic [4:0] {
    MODE_ON       = 5'h01,
    MODE_BLOCKED  = 5'h02,
    MODE_TEST     = 5'h04,
    MODE_TEST_BLK = 5'h08,
    MODE_OFF      = 5'h10
  } frsl_mode_t;

endpackage

//--- dv/frsl_monitor.sv
`timescale 1ns/1ps
module frsl_monitor #(
  parameter int unsigned PROG_CLKS = 10
) (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire frsl_pkg::frsl_mode_t mode_i,
  input wire logic                 block_i,
  input wire logic                 start_i,
  input wire logic                 hot_cold_en_i,
  input wire logic [9:0]           theta_used_i,
  input wire logic [5:0]           ev_store_sel_i,
  input wire logic                 set_we_i,
  input wire logic [2:0]           set_sel_i,
  input wire logic [12:0]          set_val_i,
  input wire logic [3:0]           hist_idx_i,
  input wire logic                 alarm_o,
  input wire logic                 lockout_o,
  input wire logic                 blocked_o,
  input wire logic                 hot_o,
  input wire logic [6:0]           used_starts_o,
  input wire logic [23:0]          lock_time_o,
  input wire logic [23:0]          since_start_o,
  input wire logic                 ev_valid_o,
  input wire logic [2:0]           ev_code_o,
  input wire logic                 ev_store_o,
  input wire logic                 hist_valid_o,
  input wire logic [9:0]           shr_hot_lim_o,
  input wire logic [6:0]           shr_starts_cold_o,
  input wire logic [6:0]           shr_starts_hot_o,
  input wire logic [12:0]          shr_min_gap_o
);
  logic [6:0] allow_w;
  logic       on_w;
  assign allow_w = hot_o ? shr_starts_hot_o : shr_starts_cold_o;
  assign on_w = (mode_i == frsl_pkg::MODE_ON) && !block_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  alarm_one_left_a: assert property (
    alarm_o |-> used_starts_o + 7'h01 == allow_w)
    else $error("alarm raised without exactly one start left");
  lock_all_used_a: assert property (
    $past(on_w) && used_starts_o >= allow_w
    |-> lockout_o) else $error("all starts used but no lockout");
  blocked_on_a: assert property (
    (mode_i == frsl_pkg::MODE_ON && block_i)[*2] |-> blocked_o)
    else $error("blocked output missing");
  blocked_off_a: assert property (on_w ##1 on_w |-> !blocked_o)
    else $error("blocked output without block");
  ev_alarm_on_a: assert property (
    $rose(alarm_o) |-> ##[1:6] (ev_valid_o && ev_code_o == 3'h0))
    else $error("no event for alarm rise");
  ev_lock_off_a: assert property (
    $fell(lockout_o) |-> ##[1:6] (ev_valid_o && ev_code_o == 3'h3))
    else $error("no event for lockout fall");
  ev_store_sel_a: assert property (
    ev_valid_o && $stable(ev_store_sel_i)
    |-> ev_store_o == ev_store_sel_i[ev_code_o])
    else $error("event store flag does not follow selection");
  gap_write_a: assert property (
    set_we_i && set_sel_i == frsl_pkg::SEL_MIN_GAP
    |=> shr_min_gap_o == $past(set_val_i)) else $error("gap write lost");
  since_clear_a: assert property (
    start_i && !block_i && (mode_i == frsl_pkg::MODE_ON
    || mode_i == frsl_pkg::MODE_TEST) |=> since_start_o == 24'h0)
    else $error("start did not clear time since start");
  hot_select_a: assert property (
    (hot_cold_en_i && theta_used_i > shr_hot_lim_o)[*2] |-> hot_o)
    else $error("hot parameters not selected");
  hist_range_a: assert property (hist_idx_i >= 4'hc |=> !hist_valid_o)
    else $error("history index past depth reads valid");
  lock_time_zero_a: assert property (
    $rose(lockout_o) |-> lock_time_o == 24'h0)
    else $error("lockout duration not restarted");
endmodule

bind frsl_limiter frsl_monitor #(.PROG_CLKS(PROG_CLKS)) u_mon (
  .ref_clk_i, .rst_i, .mode_i, .block_i, .start_i, .hot_cold_en_i,
  .theta_used_i, .ev_store_sel_i, .set_we_i, .set_sel_i, .set_val_i,
  .hist_idx_i, .alarm_o, .lockout_o, .blocked_o, .hot_o, .used_starts_o,
  .lock_time_o, .since_start_o, .ev_valid_o, .ev_code_o, .ev_store_o,
  .hist_valid_o, .shr_hot_lim_o, .shr_starts_cold_o, .shr_starts_hot_o,
  .shr_min_gap_o);

//--- dv/frsl_motor_model.sv
`timescale 1ns/1ps
module frsl_motor_model #(
  parameter int unsigned TICK = 10
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        kick_i,
  output logic             start_o,
  output logic [63:0]      timestamp_o
);
  logic        kick_q;
  int unsigned div_q;
  // The start monitor reports a start as one pulse, however long the kick.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kick_q  <= 1'b0;
      start_o <= 1'b0;
    end else begin
      kick_q  <= kick_i;
      start_o <= kick_i & ~kick_q;
    end
  end
  // Time is scaled down with the program cycle so stamps stay distinct.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q       <= 0;
      timestamp_o <= 64'h0;
    end else if (div_q == TICK - 1) begin
      div_q       <= 0;
      timestamp_o <= timestamp_o + 64'h1;
    end else begin
      div_q <= div_q + 1;
    end
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
  localparam int unsigned PCLK = 10;
  localparam logic [12:0] DEF [7] = '{13'h02bc, 13'h00c8, 13'h0096,
    13'h0003, 13'h0002, 13'h0001, 13'h00c8};
  localparam frsl_pkg::frsl_mode_t MD [4] = '{frsl_pkg::MODE_OFF,
    frsl_pkg::MODE_BLOCKED, frsl_pkg::MODE_TEST_BLK, frsl_pkg::MODE_TEST};
  localparam logic [3:0] EXP_EV [3] = '{4'h8, 4'h1, 4'h2};
  logic ref_clk_i = 1'b0, rst_i = 1'b1, block_i = 1'b0, kick = 1'b0;
  logic hot_cold_en_i = 1'b0, set_we_i = 1'b0;
  frsl_pkg::frsl_mode_t mode_i = frsl_pkg::MODE_ON;
  logic [9:0]  theta_used_i = 10'h000;
  logic [5:0]  ev_store_sel_i = 6'h09;
  logic [2:0]  set_sel_i = 3'h0;
  logic [12:0] set_val_i = 13'h0000;
  logic [3:0]  hist_idx_i = 4'h0;
  logic        start_i, alarm_o, lockout_o, blocked_o, hot_o, ev_valid_o;
  logic        ev_store_o, hist_valid_o;
  logic [63:0] timestamp_i;
  logic [6:0]  used_starts_o, hist_used_o, shr_starts_cold_o;
  logic [6:0]  shr_starts_hot_o, shr_hours_o;
  logic [23:0] lock_time_o, since_start_o, hist_lock_time_o, hist_since_o;
  logic [63:0] ev_time_o, hist_time_o;
  logic [2:0]  ev_code_o, hist_code_o;
  logic [9:0]  shr_hot_lim_o;
  logic [12:0] shr_stall_cold_o, shr_stall_hot_o, shr_min_gap_o;
  int          bad_count = 0, total_checks = 0, cycles = 0;
  logic [3:0]  evq [$];

  always #5 ref_clk_i = ~ref_clk_i;

  frsl_motor_model #(.TICK(PCLK)) partner (.ref_clk_i, .rst_i,
    .kick_i(kick), .start_o(start_i), .timestamp_o(timestamp_i));
  frsl_limiter #(.PROG_CLKS(PCLK)) dut (.ref_clk_i, .rst_i, .mode_i,
    .block_i, .start_i, .hot_cold_en_i, .theta_used_i, .timestamp_i,
    .ev_store_sel_i, .set_we_i, .set_sel_i, .set_val_i, .hist_idx_i,
    .alarm_o, .lockout_o, .blocked_o, .hot_o, .used_starts_o, .lock_time_o,
    .since_start_o, .ev_valid_o, .ev_code_o, .ev_store_o, .ev_time_o,
    .hist_valid_o, .hist_time_o, .hist_code_o, .hist_lock_time_o,
    .hist_since_o, .hist_used_o, .shr_hot_lim_o, .shr_stall_cold_o,
    .shr_stall_hot_o, .shr_starts_cold_o, .shr_starts_hot_o, .shr_hours_o,
    .shr_min_gap_o);

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hang counts as a mismatch and still ends in the closing report.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (ev_valid_o === 1'b1) begin
      evq.push_back({ev_store_o, ev_code_o});
      `CHK("evtime", 1'b1, ev_time_o != 64'h0)
    end
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [12:0] shr(input int s);
    case (s)
      0: return {3'h0, shr_hot_lim_o};
      1: return shr_stall_cold_o;
      2: return shr_stall_hot_o;
      3: return {6'h00, shr_starts_cold_o};
      4: return {6'h00, shr_starts_hot_o};
      5: return {6'h00, shr_hours_o};
      default: return shr_min_gap_o;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic set_wr(input logic [2:0] s, input logic [12:0] v);
    @(posedge ref_clk_i);
    set_we_i  <= 1'b1;
    set_sel_i <= s;
    set_val_i <= v;
    @(posedge ref_clk_i);
    set_we_i <= 1'b0;
    tick(1);
  endtask

  task automatic go(input int n);
    @(posedge ref_clk_i);
    kick <= 1'b1;
    @(posedge ref_clk_i);
    kick <= 1'b0;
    tick(n);
  endtask

  // Off empties the stress counter and the spacing lock.
  task automatic clr;
    mode_i <= frsl_pkg::MODE_OFF;
    tick(8);
    mode_i <= frsl_pkg::MODE_ON;
    tick(2);
  endtask

  initial begin
    tick(20);
    rst_i <= 1'b0;
    tick(2);
    for (int s = 0; s < 7; s++)
      `CHK("default", DEF[s], shr(s))
    `CHK("since", 24'hffffff, since_start_o)
    for (int s = 0; s < 7; s++) begin
      set_wr(3'(s), 13'h0005 + 13'(s));
      `CHK("write", 13'h0005 + 13'(s), shr(s))
    end
    for (int s = 0; s < 7; s++) begin
      set_wr(3'(s), DEF[s]);
      `CHK("restore", DEF[s], shr(s))
    end
    set_wr(3'h7, 13'h1fff);
    `CHK("sel7", 13'h00c8, shr(6))
    set_wr(frsl_pkg::SEL_MIN_GAP, 13'h0001);
    go(150);
    `CHK("used1", 7'h01, used_starts_o)
    `CHK("alarm1", 1'b0, alarm_o)
    go(150);
    `CHK("alarm2", 1'b1, alarm_o)
    go(150);
    `CHK("used3", 7'h03, used_starts_o)
    `CHK("alarm3", 1'b0, alarm_o)
    `CHK("lock3", 1'b1, lockout_o)
    tick(300);
    `CHK("locktime", 1'b1, lock_time_o != 24'h0)
    `CHK("evcount", 3, evq.size())
    for (int i = 0; i < 3; i++)
      `CHK("event", EXP_EV[i], evq[i])
    tick(2);
    `CHK("hcode0", 3'h2, hist_code_o)
    `CHK("hused0", 7'h03, hist_used_o)
    hist_idx_i <= 4'h2;
    tick(2);
    `CHK("hcode2", 3'h0, hist_code_o)
    `CHK("htime2", 1'b1, hist_time_o != 64'h0)
    `CHK("hlock2", 24'h0, hist_lock_time_o)
    `CHK("hsince2", 1'b1, hist_since_o <= 24'h1)
    hist_idx_i <= 4'hc;
    tick(2);
    `CHK("hvalid", 1'b0, hist_valid_o)
    evq.delete();
    clr();
    `CHK("lockoff", 4'hb, evq[0])
    go(10);
    go(10);
    `CHK("gaplock", 1'b1, lockout_o)
    for (int i = 0; i < 300 && lockout_o !== 1'b0; i++)
      tick(1);
    `CHK("gapfree", 1'b0, lockout_o)
    block_i <= 1'b1;
    tick(3);
    `CHK("blocked", 1'b1, blocked_o)
    go(20);
    `CHK("blkstart", 7'h02, used_starts_o)
    block_i <= 1'b0;
    tick(3);
    `CHK("unblocked", 1'b0, blocked_o)
    for (int i = 0; i < 4; i++) begin
      clr();
      mode_i <= MD[i];
      tick(2);
      go(20);
      `CHK("mode", 7'(i == 3), used_starts_o)
    end
    clr();
    hot_cold_en_i <= 1'b1;
    theta_used_i  <= 10'h2bd;
    tick(3);
    `CHK("hot", 1'b1, hot_o)
    theta_used_i <= 10'h2bc;
    tick(3);
    `CHK("atlimit", 1'b0, hot_o)
    theta_used_i <= 10'h2bd;
    go(20);
    `CHK("hotalarm", 1'b1, alarm_o)
    theta_used_i <= 10'h000;
    tick(5);
    `CHK("coldalarm", 1'b0, alarm_o)
    finish_test();
  end
endmodule
